// File: design/psx_pkg.sv
// Purpose: Constants and carrier types for the partial store and trap execution slice
// Assumes: 64-bit registers, 64-bit doubleword memory data path
// Notes: Access type codes name byte count minus one
package psx_pkg;

  // ==========================================================
  // Opcode fields
  localparam logic [5:0] OP_REG_FORMAT = 6'h00;
  localparam logic [5:0] OP_STORE_LEFT = 6'h2A;
  localparam logic [5:0] OP_STORE_RIGHT = 6'h2E;
  localparam logic [5:0] FN_SYNC = 6'h0F;
  localparam logic [5:0] FN_SYSTEM_CALL_INSTR = 6'h0C;
  localparam logic [5:0] FN_TRAP_EQ = 6'h34;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 26;
  localparam int RS_LSB = 21;
  localparam int RT_LSB = 16;

  // ==========================================================
  // Exception codes reported with an exception pulse
  typedef enum logic [2:0] {
    PSX_EXC_NONE = 3'h0,
    PSX_EXC_SYSTEM_CALL_INSTR = 3'h1,
    PSX_EXC_TRAP = 3'h2,
    PSX_EXC_TLB_REFILL = 3'h3,
    PSX_EXC_TLB_INVALID = 3'h4,
    PSX_EXC_TLB_MOD = 3'h5,
    PSX_EXC_BUS_ERR = 3'h6,
    PSX_EXC_ADDR_ERR = 3'h7
  } psx_exc_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    PSX_IDLE = 2'b00,
    PSX_XLATE = 2'b01,
    PSX_STORE = 2'b10
  } psx_state_t;

  // Request from the issue stage
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] rs_val;
    logic [63:0] rt_val;
  } psx_req_t;

  // Translation answer
  typedef struct packed {
    logic [31:0] paddr;
    logic uncached;
    logic tlb_refill;
    logic tlb_invalid;
    logic tlb_mod;
    logic addr_err;
  } psx_xlt_t;

  // Store sent to memory
  typedef struct packed {
    logic [31:0] paddr;
    logic [1:0] access_type;
    logic [2:0] offset;
    logic [63:0] data;
    logic uncached;
  } psx_mem_t;

  // Whole module state
  typedef struct packed {
    psx_state_t state;
    logic is_left;
    logic [63:0] virtual_address;
    logic [63:0] rt_val;
    psx_mem_t mem;
    logic done;
    logic exc_valid;
    psx_exc_t exc;
  } psx_regs_t;

endpackage : psx_pkg

// File: design/psx_exec.sv
// Purpose: Executes partial-word stores, synchronise, system call and trap-if-equal
// Assumes: Issue stage drops the request after the cycle it is taken; one request at a time
// Notes: Translation and store each use a valid/done handshake with the core
`timescale 1ns/1ns
module psx_exec (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CORE_ENDIAN_BIG_I,
  input wire logic MEMORY_ENDIAN_BIG_I,
  input wire logic USER_ENDIAN_SWAP_I,
  input wire logic REQ_VALID_I,
  input wire psx_pkg::psx_req_t REQ_I,
  output logic REQ_READY_O,
  output logic XLT_VALID_O,
  output logic [63:0] XLT_VIRTUAL_ADDRESS_O,
  input wire logic XLT_DONE_I,
  input wire psx_pkg::psx_xlt_t XLT_I,
  output logic MEM_VALID_O,
  output psx_pkg::psx_mem_t MEM_O,
  input wire logic MEM_DONE_I,
  input wire logic MEM_BUS_ERR_I,
  output logic DONE_O,
  output logic EXC_VALID_O,
  output psx_pkg::psx_exc_t EXC_CODE_O
);

  psx_pkg::psx_regs_t r_q;
  psx_pkg::psx_regs_t r_d;

  // ==========================================================
  // Decode
  logic [5:0] opc;
  logic [5:0] fnc;
  logic is_swl;
  logic is_swr;
  logic is_sync;
  logic is_sys;
  logic is_teq;
  logic [63:0] virtual_address_calc;
  logic [1:0] byte_idx;
  logic [2:0] paddr_lo;
  logic [63:0] sh_data;
  logic [31:0] word_data;

  assign opc = REQ_I.instr[psx_pkg::OP_MSB:psx_pkg::OP_LSB];
  assign fnc = REQ_I.instr[5:0];
  assign is_swl = opc == psx_pkg::OP_STORE_LEFT;
  assign is_swr = opc == psx_pkg::OP_STORE_RIGHT;
  // Code fields never looked at
  assign is_sync = opc == psx_pkg::OP_REG_FORMAT && fnc == psx_pkg::FN_SYNC;
  assign is_sys = opc == psx_pkg::OP_REG_FORMAT && fnc == psx_pkg::FN_SYSTEM_CALL_INSTR;
  assign is_teq = opc == psx_pkg::OP_REG_FORMAT && fnc == psx_pkg::FN_TRAP_EQ;

  // Sign-extended offset plus base
  assign virtual_address_calc = REQ_I.rs_val + {{48{REQ_I.instr[15]}}, REQ_I.instr[15:0]};

  // Byte index follows core endianness
  assign byte_idx = r_q.virtual_address[1:0] ^ {2{CORE_ENDIAN_BIG_I}};

  // Physical low bits after user endian swap
  assign paddr_lo = XLT_I.paddr[2:0] ^ {3{USER_ENDIAN_SWAP_I}};

  // Merged data lanes for both partial stores
  always_comb begin
    if (r_q.is_left) begin
      word_data = 32'(r_q.rt_val[31:0] >> (6'd24 - {byte_idx, 3'b000}));
    end else begin
      word_data = 32'(r_q.rt_val[31:0] << {byte_idx, 3'b000});
    end
    if ((r_q.virtual_address[2] ^ CORE_ENDIAN_BIG_I) == 1'b0) begin
      sh_data = {32'h0000_0000, word_data};
    end else begin
      sh_data = {word_data, 32'h0000_0000};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.exc_valid = 1'b0;
    r_d.exc = psx_pkg::PSX_EXC_NONE;
    unique case (r_q.state)
      psx_pkg::PSX_IDLE: begin
        if (REQ_VALID_I) begin
          r_d.virtual_address = virtual_address_calc;
          r_d.rt_val = REQ_I.rt_val;
          r_d.is_left = is_swl;
          if (is_swl || is_swr) begin
            r_d.state = psx_pkg::PSX_XLATE;
          end else if (is_sys) begin
            r_d.exc_valid = 1'b1;
            r_d.exc = psx_pkg::PSX_EXC_SYSTEM_CALL_INSTR;
          end else if (is_teq && REQ_I.rs_val == REQ_I.rt_val) begin
            r_d.exc_valid = 1'b1;
            r_d.exc = psx_pkg::PSX_EXC_TRAP;
          end else if (is_sync) begin
            // Synchronise completes with no exception
            r_d.done = 1'b1;
          end else begin
            // Other codes retire quietly as no-ops
            r_d.done = 1'b1;
          end
        end
      end
      psx_pkg::PSX_XLATE: begin
        if (XLT_DONE_I) begin
          if (XLT_I.tlb_refill || XLT_I.tlb_invalid || XLT_I.tlb_mod || XLT_I.addr_err) begin
            r_d.state = psx_pkg::PSX_IDLE;
            r_d.exc_valid = 1'b1;
            if (XLT_I.tlb_refill) begin
              r_d.exc = psx_pkg::PSX_EXC_TLB_REFILL;
            end else if (XLT_I.tlb_invalid) begin
              r_d.exc = psx_pkg::PSX_EXC_TLB_INVALID;
            end else if (XLT_I.tlb_mod) begin
              r_d.exc = psx_pkg::PSX_EXC_TLB_MOD;
            end else begin
              r_d.exc = psx_pkg::PSX_EXC_ADDR_ERR;
            end
          end else begin
            r_d.state = psx_pkg::PSX_STORE;
            r_d.mem.paddr = {XLT_I.paddr[31:3], paddr_lo};
            // Low bits cleared toward word lane per memory endianness
            if (r_q.is_left && !MEMORY_ENDIAN_BIG_I) begin
              r_d.mem.paddr[1:0] = 2'b00;
            end
            if (!r_q.is_left && MEMORY_ENDIAN_BIG_I) begin
              r_d.mem.paddr[1:0] = 2'b00;
            end
            r_d.mem.offset = r_d.mem.paddr[2:0];
            if (r_q.is_left) begin
              r_d.mem.access_type = byte_idx;
            end else begin
              r_d.mem.access_type = 2'd3 - byte_idx;
            end
            r_d.mem.data = sh_data;
            r_d.mem.uncached = XLT_I.uncached;
          end
        end
      end
      psx_pkg::PSX_STORE: begin
        if (MEM_BUS_ERR_I) begin
          r_d.state = psx_pkg::PSX_IDLE;
          r_d.exc_valid = 1'b1;
          r_d.exc = psx_pkg::PSX_EXC_BUS_ERR;
        end else if (MEM_DONE_I) begin
          r_d.state = psx_pkg::PSX_IDLE;
          r_d.done = 1'b1;
        end
      end
      default: begin
        r_d.state = psx_pkg::PSX_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign REQ_READY_O = r_q.state == psx_pkg::PSX_IDLE;
  assign XLT_VALID_O = r_q.state == psx_pkg::PSX_XLATE;
  assign XLT_VIRTUAL_ADDRESS_O = r_q.virtual_address;
  assign MEM_VALID_O = r_q.state == psx_pkg::PSX_STORE;
  assign MEM_O = r_q.mem;
  assign DONE_O = r_q.done;
  assign EXC_VALID_O = r_q.exc_valid;
  assign EXC_CODE_O = r_q.exc;

endmodule : psx_exec

// File: sim/psx_exec_asserts.sv
// Purpose: Port checks for psx_exec
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every psx_exec by name
`timescale 1ns/1ns
module psx_exec_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  input wire psx_pkg::psx_req_t REQ_I,
  input wire logic REQ_READY_O,
  input wire logic XLT_VALID_O,
  input wire logic XLT_DONE_I,
  input wire psx_pkg::psx_xlt_t XLT_I,
  input wire logic MEM_VALID_O,
  input wire psx_pkg::psx_mem_t MEM_O,
  input wire logic MEM_DONE_I,
  input wire logic MEM_BUS_ERR_I,
  input wire logic DONE_O,
  input wire logic EXC_VALID_O,
  input wire psx_pkg::psx_exc_t EXC_CODE_O
);
  // ==========================
  // Taken requests and answers
  wire sp = REQ_VALID_I && REQ_READY_O && REQ_I.instr[31:26] == 6'h00;
  wire [5:0] fn = REQ_I.instr[5:0];
  wire xa = XLT_VALID_O && XLT_DONE_I;
  wire ma = MEM_VALID_O && MEM_BUS_ERR_I;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_sync; sp && fn == 6'h0F |=> DONE_O && !EXC_VALID_O; endproperty
  a_sync: assert property (p_sync) else $error("sync not a no-op");
  property p_sys; sp && fn == 6'h0C |=> EXC_VALID_O && EXC_CODE_O == 3'h1; endproperty
  a_sys: assert property (p_sys) else $error("no system call");
  property p_teq; sp && fn == 6'h34 && REQ_I.rs_val == REQ_I.rt_val
    |=> EXC_VALID_O && EXC_CODE_O == 3'h2; endproperty
  a_teq: assert property (p_teq) else $error("no trap");
  property p_noal; xa && XLT_I[3:0] == 4'h0 |=> MEM_VALID_O && !EXC_VALID_O; endproperty
  a_noal: assert property (p_noal) else $error("store refused");
  property p_tlb; xa && XLT_I.tlb_refill |=> EXC_VALID_O && EXC_CODE_O == 3'h3; endproperty
  a_tlb: assert property (p_tlb) else $error("refill lost");
  property p_bus; ma |=> EXC_VALID_O && EXC_CODE_O == 3'h6; endproperty
  a_bus: assert property (p_bus) else $error("bus error lost");
  property p_off; MEM_VALID_O |-> MEM_O.offset == MEM_O.paddr[2:0]; endproperty
  a_off: assert property (p_off) else $error("offset differs");
  property p_hold; MEM_VALID_O && !MEM_DONE_I && !ma |=> MEM_VALID_O && $stable(MEM_O);
  endproperty
  a_hold: assert property (p_hold) else $error("store dropped");
  c_st: cover property (MEM_VALID_O && MEM_DONE_I);
  c_tr: cover property (EXC_VALID_O && EXC_CODE_O == 3'h2);
  c_b2b: cover property (DONE_O && REQ_VALID_I);
endmodule : psx_exec_asserts

bind psx_exec psx_exec_asserts u_chk (.*);

// File: sim/psx_mem_model.sv
// Purpose: Translation and store path partner for psx_exec
// Assumes: Low 32 address bits translate unchanged
// Notes: wait_i sets answer delay, fault_i picks a fault
`timescale 1ns/1ns
module psx_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] wait_i,
  input wire psx_pkg::psx_exc_t fault_i,
  input wire logic xlt_valid_i,
  input wire logic [63:0] virtual_address_i,
  output logic xlt_done_o,
  output psx_pkg::psx_xlt_t xlt_o,
  input wire logic mem_valid_i,
  output logic mem_done_o,
  output logic mem_err_o
);
  // ==========================
  // Wait counters
  logic [1:0] xc;
  logic [1:0] mc;
  always_ff @(posedge clk_i) begin
    xc <= (rst_n_i && xlt_valid_i && !xlt_done_o) ? xc + 2'h1 : 2'h0;
    mc <= (rst_n_i && mem_valid_i && !mem_done_o && !mem_err_o) ? mc + 2'h1 : 2'h0;
  end
  // Answers; translation data inverted outside the answer cycle
  assign xlt_done_o = xlt_valid_i && xc == wait_i;
  assign xlt_o = {virtual_address_i[31:0], 1'b0, fault_i == 3'h3, fault_i == 3'h4, fault_i == 3'h5,
    fault_i == 3'h7} ^ {37{!xlt_done_o}};
  assign mem_done_o = mem_valid_i && mc == wait_i && fault_i != 3'h6;
  assign mem_err_o = mem_valid_i && mc == wait_i && fault_i == 3'h6;
endmodule : psx_mem_model

// File: sim/psx_exec_tb.sv
// Purpose: Self-checking bench for psx_exec
// Assumes: Inputs move 1 ns after the rising edge
// Notes: Partner model answers translation and stores
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module psx_exec_tb;
  logic CORE_CLK_I = 0, RST_N_I = 0, CORE_ENDIAN_BIG_I = 0, MEMORY_ENDIAN_BIG_I = 0;
  logic USER_ENDIAN_SWAP_I = 0, REQ_VALID_I = 0, REQ_READY_O, XLT_VALID_O, XLT_DONE_I;
  logic MEM_VALID_O, MEM_DONE_I, MEM_BUS_ERR_I, DONE_O, EXC_VALID_O;
  logic [63:0] XLT_VIRTUAL_ADDRESS_O;
  logic [1:0] wt = 2'h0;
  psx_pkg::psx_req_t REQ_I = '0;
  psx_pkg::psx_xlt_t XLT_I;
  psx_pkg::psx_mem_t MEM_O, got;
  psx_pkg::psx_exc_t EXC_CODE_O, ft = psx_pkg::PSX_EXC_NONE;
  int mismatches = 0, n_checks = 0;
  // ==========================
  // Design, partner and clock
  psx_exec dut (.*);
  psx_mem_model u_mem (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I), .wait_i(wt), .fault_i(ft),
    .xlt_valid_i(XLT_VALID_O), .virtual_address_i(XLT_VIRTUAL_ADDRESS_O), .xlt_done_o(XLT_DONE_I), .xlt_o(XLT_I),
    .mem_valid_i(MEM_VALID_O), .mem_done_o(MEM_DONE_I), .mem_err_o(MEM_BUS_ERR_I));
  initial forever #5 CORE_CLK_I = ~CORE_CLK_I;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // One instruction; returns in the cycle of its done or exception pulse
  task automatic run(input logic [31:0] ins, input logic [63:0] rs, input logic [63:0] rt);
    int i;
    REQ_I = {ins, rs, rt};
    REQ_VALID_I = 1;
    got = '1;
    @(posedge CORE_CLK_I);
    #1 REQ_VALID_I = 0;
    for (i = 0; i < 20 && !DONE_O && !EXC_VALID_O; i++) begin
      if (MEM_VALID_O && MEM_DONE_I) got = MEM_O;
      @(posedge CORE_CLK_I);
      #1;
    end
    if (i == 20) begin
      mismatches++;
      end_sim;
    end
  endtask : run
  // Register-format no-op, system call and trap
  task automatic t_plain;
    run(32'h0000000F, 64'h1, 64'h2);
    `CHK("sync", 2'b10, {DONE_O, EXC_VALID_O})
    run(32'h03FFFFCC, 64'h1, 64'h1);
    `CHK("system_call_instr", 3'h1, EXC_CODE_O)
    run(32'h0022FFF4, 64'h8000000000000005, 64'h8000000000000005);
    `CHK("trap eq", 3'h2, EXC_CODE_O)
    run(32'h0022FFF4, 64'h8000000000000005, 64'h5);
    `CHK("trap ne", 2'b10, {DONE_O, EXC_VALID_O})
  endtask : t_plain
  // Partial store at every byte of a doubleword
  task automatic t_store(input logic lf, input logic c, input logic m, input logic s);
    logic [1:0] b;
    logic [2:0] pa;
    logic [31:0] w;
    logic [63:0] va;
    logic [63:0] rt;
    rt = 64'hA1B2C3D4E5F60718;
    for (int n = 0; n < 8; n++) begin
      {CORE_ENDIAN_BIG_I, MEMORY_ENDIAN_BIG_I, USER_ENDIAN_SWAP_I, wt} = {c, m, s, n[1:0]};
      va = 64'h100 + n;
      run({lf ? 6'h2A : 6'h2E, 5'h1, 5'h2, 16'hFFF0 + 16'(n)}, 64'h110, rt);
      b = va[1:0] ^ {2{c}};
      pa = va[2:0] ^ {3{s}};
      if (lf ? !m : m) pa[1:0] = 2'h0;
      w = lf ? rt[31:0] >> (24 - 8 * b) : rt[31:0] << (8 * b);
      `CHK("done", 1'b1, DONE_O)
      `CHK("ready", 1'b1, REQ_READY_O)
      `CHK("virtual_address", va, XLT_VIRTUAL_ADDRESS_O)
      `CHK("paddr", {va[31:3], pa}, got.paddr)
      `CHK("type", lf ? b : 2'h3 - b, got.access_type)
      `CHK("offset", pa, got.offset)
      `CHK("data", (va[2] ^ c) ? {w, 32'h0} : {32'h0, w}, got.data)
    end
  endtask : t_store
  // Each store fault
  task automatic t_faults;
    for (int k = 3; k < 8; k++) begin
      ft = psx_pkg::psx_exc_t'(k);
      run({6'h2E, 5'h1, 5'h2, 16'h0003}, 64'h0, 64'h0);
      `CHK("fault", ft, EXC_CODE_O)
    end
    ft = psx_pkg::PSX_EXC_NONE;
  endtask : t_faults
  // Main sequence
  initial begin
    repeat (3) @(posedge CORE_CLK_I);
    #1 RST_N_I = 1;
    t_plain;
    t_store(1'b1, 1'b0, 1'b0, 1'b0);
    t_store(1'b0, 1'b0, 1'b0, 1'b0);
    t_store(1'b0, 1'b1, 1'b1, 1'b1);
    t_store(1'b1, 1'b1, 1'b0, 1'b1);
    t_faults;
    end_sim;
  end
endmodule : psx_exec_tb
